/* File: core/ifpub_defines.svh */
`ifndef IFPUB_DEFINES_SVH
`define IFPUB_DEFINES_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define IFPUB_FORCE_OFF 12'h000
`define IFPUB_CLEAR_OFF 12'h004
`define IFPUB_ENABLE_OFF 12'h008
`define IFPUB_IRQ_STAT_OFF 12'h00C
`define IFPUB_IRQ_EN_OFF 12'h010
`define IFPUB_IRQ_CLR_OFF 12'h014
// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define IFPUB_NLINES 18
`define IFPUB_FIRST_LINE 32
`define IFPUB_PEND_RST 18'h00000
`define IFPUB_ENA_RST 18'h00000
`define IFPUB_IRQ_RST 2'h0
`define IFPUB_EV_SET 0
`define IFPUB_EV_NEW 1
`endif

/* File: core/ifpub_pkg.sv */
`include "ifpub_defines.svh"
package ifpub_pkg;
   typedef logic [`IFPUB_NLINES-1:0] ifpub_lines_t;
   typedef logic [31:0] ifpub_word_t;
endpackage : ifpub_pkg

/* File: core/ifpub_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for a bundle of source levels
module ifpub_sync
   import ifpub_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // Data
   input wire ifpub_lines_t din,
   output ifpub_lines_t dout
);
   ifpub_lines_t meta_r, meta_nxt, sync_r, sync_nxt;

   // Next values of the two stages
   always_comb begin
      meta_nxt = clk_en ? din : meta_r;
      sync_nxt = clk_en ? meta_r : sync_r;
   end

   // Register stages
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= `IFPUB_PEND_RST;
         sync_r <= `IFPUB_PEND_RST;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign dout = sync_r;
endmodule : ifpub_sync
`default_nettype wire

/* File: core/ifpub_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ifpub_top
   import ifpub_pkg::*;
(
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt sources, lines 32..49 (asynchronous levels)
   input wire ifpub_lines_t irq_src,
   // Pending lines toward the core
   output ifpub_lines_t pending_out,
   // Summary interrupt
   output logic irq
);
   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   // Word match on the upper address bits; byte lanes are ignored
   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a[11:2] == o[11:2]);
   endfunction : hit

   // Lines above the bank width are dropped on write
   function automatic ifpub_lines_t low_bits(input logic [31:0] d);
      low_bits = d[`IFPUB_NLINES-1:0];
   endfunction : low_bits

   // ----------------------------------------
   // Source synchronisation
   // ----------------------------------------
   // Sources are asynchronous levels; only the second stage is read
   ifpub_lines_t src_s;
   ifpub_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .din(irq_src),
      .dout(src_s)
   );

   // ----------------------------------------
   // State
   // ----------------------------------------
   // Pending bank, line enables and the delayed source for edges
   ifpub_lines_t pend_r, pend_nxt, ena_r, ena_nxt, src_q_r, src_q_nxt;
   // Status, its enables and the summary output
   logic [1:0] ist_r, ist_nxt, ien_r, ien_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic irq_r, irq_nxt;
   // Bus side
   logic acc, wr, rd, mapped;
   logic ready_r, ready_nxt, err_r, err_nxt;
   ifpub_lines_t force_v, clear_v, rise_v, set_v, arm_v;
   logic set_ev, new_ev;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   // Access phase qualifier; nothing is taken while the enable is low
   assign acc = psel & penable & clk_en;
   // Writes land only at the edge that completes the transfer, so a
   // clear or a force is applied exactly once per bus write
   assign wr = acc & pwrite & ready_r;
   // Read data is captured in the wait cycle and stands with ready
   assign rd = acc & ~pwrite & ~ready_r;
   // Any of the six register words; the rest answer with an error
   assign mapped = hit(paddr, `IFPUB_FORCE_OFF) |
                   hit(paddr, `IFPUB_CLEAR_OFF) |
                   hit(paddr, `IFPUB_ENABLE_OFF) |
                   hit(paddr, `IFPUB_IRQ_STAT_OFF) |
                   hit(paddr, `IFPUB_IRQ_EN_OFF) |
                   hit(paddr, `IFPUB_IRQ_CLR_OFF);

   // ----------------------------------------
   // Pending bank
   // ----------------------------------------
   // Pending set and clear terms; a disabled line takes no set at all
   always_comb begin
      force_v = (wr && hit(paddr, `IFPUB_FORCE_OFF)) ?
                low_bits(pwdata) : '0;
      clear_v = (wr && hit(paddr, `IFPUB_CLEAR_OFF)) ?
                low_bits(pwdata) : '0;
      rise_v = clk_en ? (src_s & ~src_q_r) : '0;
      arm_v = (force_v | rise_v) & ena_r;
      // Only lines that were not yet pending count as newly pended
      set_v = arm_v & ~pend_r;
      set_ev = |set_v;
      new_ev = |(rise_v & ena_r);
   end

   // Next state of the pending bank and enables
   // Pending holds after its source falls; only a clear drops it
   always_comb begin
      pend_nxt = pend_r;
      ena_nxt = ena_r;
      src_q_nxt = clk_en ? src_s : src_q_r;
      if (clk_en) begin
         // Set wins over a clear in the same cycle, also for a line
         // that was already pending when its source rose again
         pend_nxt = (pend_r & ~clear_v) | arm_v;
      end
      if (wr && hit(paddr, `IFPUB_ENABLE_OFF)) begin
         ena_nxt = low_bits(pwdata);
      end
   end

   // ----------------------------------------
   // Interrupt status
   // ----------------------------------------
   // Interrupt status, enable and output
   // Status bits are sticky; a clear loses to an event in the same cycle
   always_comb begin
      ist_nxt = ist_r;
      ien_nxt = ien_r;
      if (wr && hit(paddr, `IFPUB_IRQ_CLR_OFF)) begin
         ist_nxt = ist_r & ~pwdata[1:0];
      end
      if (wr && hit(paddr, `IFPUB_IRQ_EN_OFF)) begin
         ien_nxt = pwdata[1:0];
      end
      if (clk_en) begin
         ist_nxt[`IFPUB_EV_SET] = ist_nxt[`IFPUB_EV_SET] | set_ev;
         ist_nxt[`IFPUB_EV_NEW] = ist_nxt[`IFPUB_EV_NEW] | new_ev;
      end
      irq_nxt = clk_en ? |(ist_nxt & ien_nxt) : irq_r;
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   // Read data mux; unused upper bits read zero
   // Write-only and unmapped words read as zero
   always_comb begin
      prdata_nxt = prdata_r;
      if (rd) begin
         prdata_nxt = 32'h00000000;
         if (hit(paddr, `IFPUB_FORCE_OFF)) begin
            prdata_nxt[`IFPUB_NLINES-1:0] = pend_r;
         end else if (hit(paddr, `IFPUB_ENABLE_OFF)) begin
            prdata_nxt[`IFPUB_NLINES-1:0] = ena_r;
         end else if (hit(paddr, `IFPUB_IRQ_STAT_OFF)) begin
            prdata_nxt[1:0] = ist_r;
         end else if (hit(paddr, `IFPUB_IRQ_EN_OFF)) begin
            prdata_nxt[1:0] = ien_r;
         end
      end
   end

   // ----------------------------------------
   // State registers
   // ----------------------------------------
   // Register all state but the handshake flags; the reset branch loads constants only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_r <= `IFPUB_PEND_RST;
         ena_r <= `IFPUB_ENA_RST;
         src_q_r <= `IFPUB_PEND_RST;
         ist_r <= `IFPUB_IRQ_RST;
         ien_r <= `IFPUB_IRQ_RST;
         irq_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else begin
         pend_r <= pend_nxt;
         ena_r <= ena_nxt;
         src_q_r <= src_q_nxt;
         ist_r <= ist_nxt;
         ien_r <= ien_nxt;
         irq_r <= irq_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // ----------------------------------------
   // APB handshake
   // ----------------------------------------
   // One wait cycle, registered answer; ready stands for one cycle and
   // the error flag stands with it for an unmapped word
   always_comb begin
      ready_nxt = ready_r;
      err_nxt = err_r;
      if (clk_en) begin
         ready_nxt = psel & penable & ~ready_r;
         err_nxt = psel & penable & ~ready_r & ~mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_r <= 1'b0;
         err_r <= 1'b0;
      end else begin
         ready_r <= ready_nxt;
         err_r <= err_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Every output comes straight from a flip-flop
   assign pready = ready_r;
   assign pslverr = err_r;
   assign prdata = prdata_r;
   assign pending_out = pend_r;
   assign irq = irq_r;
endmodule : ifpub_top
`default_nettype wire

/* File: tb/ifpub_props.sv */
`timescale 1ns/1ps
`default_nettype none
// Port checker for the force-pending bank
module ifpub_props
   import ifpub_pkg::*;
(
   // Clock, reset and bus
   input wire logic pclk, presetn, clk_en, psel, penable, pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic pready, pslverr, irq,
   // Lines
   input wire ifpub_lines_t irq_src, pending_out
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Write strobe at the edge that completes the transfer
   wire logic wr = psel & penable & pwrite & clk_en & pready;
   // Sources quiet long enough that no synced edge is in flight
   sequence quiet;
      $stable(irq_src) [*6];
   endsequence
   sequence fwr;
      quiet ##0 wr && paddr == 12'h000;
   endsequence
   keep_pend_a: assert property (fwr |=>
      (pending_out | $past(pending_out)) == pending_out)
      else $error("pending bit lost on force");
   zero_wr_a: assert property (fwr ##0 pwdata[17:0] == 18'h00000 |=>
      (pending_out & ~$past(pending_out)) == 18'h00000)
      else $error("zero write pended a line");
   clr_bits_a: assert property (quiet ##0 wr && paddr == 12'h004 |=>
      (pending_out & $past(pwdata[17:0])) == 18'h00000)
      else $error("clear ignored");
   live_rd_a: assert property (pready && !pwrite && paddr == 12'h000 |->
      prdata[17:0] == $past(pending_out))
      else $error("stale pending read");
   hi_zero_a: assert property (pready && !pwrite |->
      prdata[31:18] == 14'h0000)
      else $error("upper bits not zero");
   one_wait_a: assert property (psel && !penable ##1 penable && clk_en
      |-> !pready ##1 pready)
      else $error("wait state wrong");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held");
endmodule : ifpub_props
bind ifpub_top ifpub_props u_props (.*);
`default_nettype wire

/* File: tb/ifpub_src.sv */
`timescale 1ns/1ps
`default_nettype none
// Source lines: levels move just after an edge
module ifpub_src
   import ifpub_pkg::*;
(
   input wire logic pclk,
   input wire ifpub_lines_t req,
   output var ifpub_lines_t irq_src
);
   initial irq_src = 18'h00000;
   always @(posedge pclk) irq_src <= req;
endmodule : ifpub_src
`default_nettype wire

/* File: tb/ifpub_test.sv */
`timescale 1ns/1ps
`default_nettype none
// Bench for the upper force-pending bank
module irq_force_pending_upper_bank_test
   import ifpub_pkg::*;
;
   logic pclk = 1'h0, presetn = 1'h0, clk_en = 1'h1, psel = 1'h0;
   logic penable = 1'h0, pwrite = 1'h0, pready, pslverr, irq, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   ifpub_lines_t irq_src, pending_out, req = 18'h00000;
   int fail_count = 0, n_checks = 0, cyc = 0;
   ifpub_top dut (.*);
   ifpub_src src (.*);
   // Clock
   initial forever #4 pclk = ~pclk;
   // Hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 4000) begin
         fail_count++;
         summarize();
      end
   end
   task chk(input string n, input logic [31:0] e, s);
      n_checks++;
      if (s !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, s);
         fail_count++;
      end
   endtask : chk
   // One transfer, released a cycle before the next setup
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      q = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask : apb
   task t_set;
      apb(1, 12'h000, 32'h00000020);
      apb(0, 12'h000, 32'h0);
      chk("disabled", 32'h0, q);
      apb(1, 12'h008, 32'h0003FFFF);
      apb(1, 12'h000, 32'hFFFE0001);
      apb(0, 12'h000, 32'h0);
      chk("forced", 32'h00020001, q);
      chk("lines", 32'h00020001, 32'(pending_out));
      apb(1, 12'h000, 32'h0);
      apb(0, 12'h000, 32'h0);
      chk("zero write", 32'h00020001, q);
      apb(1, 12'h004, 32'h00000001);
      apb(0, 12'h000, 32'h0);
      chk("cleared", 32'h00020000, q);
      $display("t_set done");
   endtask : t_set
   task t_irq;
      apb(1, 12'h014, 32'h3);
      req <= 18'h00008;
      while (pending_out[3] !== 1'h1) @(posedge pclk);
      chk("masked", 32'h0, 32'(irq));
      apb(0, 12'h00C, 32'h0);
      chk("status", 32'h00000003, q);
      apb(1, 12'h010, 32'h3);
      @(posedge pclk);
      chk("raised", 32'h1, 32'(irq));
      apb(1, 12'h014, 32'h3);
      @(posedge pclk);
      chk("irq cleared", 32'h0, 32'(irq));
      apb(0, 12'h040, 32'h0);
      chk("unmapped", 32'h1, 32'(err));
      $display("t_irq done");
   endtask : t_irq
   // Enable low freezes the bank; the edge is taken after resume
   task t_hold;
      clk_en <= 1'h0;
      req <= 18'h00018;
      repeat (8) @(posedge pclk);
      chk("frozen", 32'h00020008, 32'(pending_out));
      clk_en <= 1'h1;
      repeat (6) @(posedge pclk);
      chk("resumed", 32'h00020018, 32'(pending_out));
      $display("t_hold done");
   endtask : t_hold
   // Reset then scenarios
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      t_set();
      t_irq();
      t_hold();
      summarize();
   end
   task summarize;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize
endmodule : irq_force_pending_upper_bank_test
`default_nettype wire
